/* File: src/acr_params.svh */
// Purpose: constants of the converter control block
// Assumes: included by its bare name
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_IDX_RESULT_LOW 8'h78
`define ACR_IDX_RESULT_HIGH 8'h79
`define ACR_IDX_CTRL_STATUS_A 8'h7A
`define ACR_IDX_TRIG_SELECT 8'h7B
`define ACR_IDX_INPUT_SELECT 8'h7C

`define ACR_CSA_ENABLE 7
`define ACR_CSA_START 6
`define ACR_CSA_AUTO_TRIG 5
`define ACR_CSA_FLAG 4
`define ACR_CSA_IRQ_EN 3
`define ACR_MUX_LEFT_ALIGN 5
`define ACR_MUX_RESERVED 4

`define ACR_RESET_BYTE 8'h00
`define ACR_RESET_RESULT 10'h000

`define ACR_CYCLES_FIRST 5'h19
`define ACR_CYCLES_NORMAL 5'h0D
`define ACR_TRIG_FREE_RUN 3'h0

`endif

/* File: src/acr_pkg.sv */
// Purpose: types shared by the converter control block and its bench
// Assumes: APB with 32-bit data
// Notes: constants live in acr_params.svh
package acr_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } acr_apb_rsp_t;

    typedef enum logic [1:0] {
        ACR_REF_EXT_PIN = 2'b00,
        ACR_REF_SUPPLY = 2'b01,
        ACR_REF_RESERVED = 2'b10,
        ACR_REF_INT_1V1 = 2'b11
    } acr_ref_t;

    // analog routing handed to the sampling circuitry
    typedef struct packed {
        acr_ref_t reference_select;
        logic [3:0] input_channel_select;
    } acr_path_t;

endpackage : acr_pkg

/* File: src/acr_ctrl.sv */
// Purpose: register control of a 10-bit successive-approximation converter over APB
// Assumes: one clock, synchronous reset; analog result and trigger flags are on ref_clk
// Notes: the analog core samples path_out while conv_busy is high and holds analog_result
//        valid on the cycle conversion ends
//
// Functional notes
// - two-bit field picks external pin, supply, reserved or internal 1.1V reference.
// - reference and channel changes during a conversion wait until it completes.
// - left-align bit reshapes result view at once, even mid-conversion.
// - unused bit 4 of input select always reads zero.
// - channel codes: 0-7 pins, 8 temperature, 14 bandgap, 15 ground, others reserved.
// - enable bit turns converter on or off; clearing it aborts a conversion.
// - writing one to start begins a conversion; free running needs only the first.
// - first conversion after enabling takes 25 converter cycles, later ones 13.
// - start reads one while converting, clears at completion; writing zero does nothing.
// - with auto trigger on, a rising edge of the selected source starts a conversion.
// - completion flag sets when conversion ends and result registers are updated; here it also sets when a frozen result is dropped.
// - flag clears on interrupt vector entry or a written one; zero leaves it.
// - interrupt requested only when enable, global mask and flag are all set.
// - prescaler codes 0 and 1 divide by 2, then 4 up to 128 at code 7.
// - right aligned: 9:8 in high byte low bits; left: 9:2 high, 1:0 low 7:6.
// - after a low byte read, both bytes freeze until the high byte is read.
// - trigger is a rising edge of the selected flag; selecting free run never triggers.
// - result is an unsigned 10-bit code, zero at ground.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register bus
    input wire acr_pkg::acr_apb_req_t apb_req,
    output acr_pkg::acr_apb_rsp_t apb_rsp,
    // processor side
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic irq_req,
    // trigger flags, index is the trigger source code; bit 0 unused
    input wire logic [7:0] trigger_flags,
    // analog core
    input wire logic [9:0] analog_result,
    output acr_pkg::acr_path_t path_out,
    output logic converter_on,
    output logic conv_busy,
    output logic conv_long
);
    import acr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding

    // terminal count of the prescaler, one less than the division factor
    function automatic logic [6:0] acr_div_last(input logic [2:0] code);
        case (code)
            3'h0: acr_div_last = 7'h01;
            3'h1: acr_div_last = 7'h01;
            3'h2: acr_div_last = 7'h03;
            3'h3: acr_div_last = 7'h07;
            3'h4: acr_div_last = 7'h0F;
            3'h5: acr_div_last = 7'h1F;
            3'h6: acr_div_last = 7'h3F;
            default: acr_div_last = 7'h7F;
        endcase
    endfunction : acr_div_last

    function automatic logic acr_idx_hit(input logic [11:0] addr, input logic [7:0] idx);
        acr_idx_hit = (addr == {2'b00, idx, 2'b00});
    endfunction : acr_idx_hit

    logic [1:0] ref_sel_q;
    logic left_align_q;
    logic [3:0] chan_q;
    logic en_q;
    logic busy_q;
    logic ate_q;
    logic flag_q;
    logic ie_q;
    logic [2:0] div_q;
    logic [2:0] trig_sel_q;
    logic [9:0] res_q;
    logic lock_q;
    logic first_q;
    logic long_q;
    logic [4:0] cyc_q;
    logic [6:0] pre_q;
    logic trig_prev_q;
    acr_path_t path_q;
    acr_apb_rsp_t rsp_q;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire sel_low = acr_idx_hit(apb_req.paddr, `ACR_IDX_RESULT_LOW);
    wire sel_high = acr_idx_hit(apb_req.paddr, `ACR_IDX_RESULT_HIGH);
    wire sel_csa = acr_idx_hit(apb_req.paddr, `ACR_IDX_CTRL_STATUS_A);
    wire sel_trig = acr_idx_hit(apb_req.paddr, `ACR_IDX_TRIG_SELECT);
    wire sel_mux = acr_idx_hit(apb_req.paddr, `ACR_IDX_INPUT_SELECT);
    wire sel_any = sel_low | sel_high | sel_csa | sel_trig | sel_mux;
    // one wait state: pready rises in the second access cycle
    wire acc_phase = apb_req.psel & apb_req.penable;
    wire acc_done = acc_phase & rsp_q.pready;
    wire wr_ok = acc_done & apb_req.pwrite & sel_any;
    wire wr_csa = wr_ok & sel_csa;
    wire wr_mux = wr_ok & sel_mux;
    wire wr_trig = wr_ok & sel_trig;
    wire rd_low_done = acc_done & ~apb_req.pwrite & sel_low;
    wire rd_high_done = acc_done & ~apb_req.pwrite & sel_high;
    wire [7:0] wbyte = apb_req.pwdata[7:0];

    // read views
    wire [7:0] view_low = left_align_q ? {res_q[1:0], 6'h00} : res_q[7:0];
    wire [7:0] view_high = left_align_q ? res_q[9:2] : {6'h00, res_q[9:8]};
    wire [7:0] view_mux = {ref_sel_q, left_align_q, 1'b0, chan_q};
    wire [7:0] view_csa = {en_q, busy_q, ate_q, flag_q, ie_q, div_q};
    wire [7:0] view_trig = {5'h00, trig_sel_q};
    wire [7:0] view_any = sel_low ? view_low :
                          sel_high ? view_high :
                          sel_csa ? view_csa :
                          sel_trig ? view_trig :
                          sel_mux ? view_mux : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion sequencing

    wire en_next = wr_csa ? wbyte[`ACR_CSA_ENABLE] : en_q;
    wire enabling = wr_csa & wbyte[`ACR_CSA_ENABLE] & ~en_q;
    wire tick = en_q & (pre_q == acr_div_last(div_q));
    wire [4:0] cyc_last = long_q ? (`ACR_CYCLES_FIRST - 5'h01) : (`ACR_CYCLES_NORMAL - 5'h01);
    wire conv_done = busy_q & tick & (cyc_q == cyc_last);
    // free run has no external flag, so switching to it cannot make an edge
    wire trig_now = (trig_sel_q == `ACR_TRIG_FREE_RUN) ? 1'b0 : trigger_flags[trig_sel_q];
    wire trig_edge = trig_now & ~trig_prev_q;
    wire free_run = ate_q & (trig_sel_q == `ACR_TRIG_FREE_RUN);
    wire start_wr = wr_csa & wbyte[`ACR_CSA_START] & wbyte[`ACR_CSA_ENABLE];
    wire start_trig = ate_q & trig_edge & en_q;
    wire restart = conv_done & free_run & en_next;
    wire start_any = ((start_wr | start_trig) & ~busy_q & en_next) | restart;
    wire first_now = first_q | enabling;
    wire take_result = conv_done & (~lock_q | rd_high_done);
    wire flag_clr = irq_vector_ack | (wr_csa & wbyte[`ACR_CSA_FLAG]);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            cyc_q <= 5'h00;
            long_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            if (!en_next) begin
                busy_q <= 1'b0;
            end else if (start_any) begin
                busy_q <= 1'b1;
            end else if (conv_done) begin
                busy_q <= 1'b0;
            end
            if (start_any) begin
                cyc_q <= 5'h00;
                long_q <= first_now;
            end else if (busy_q && tick) begin
                cyc_q <= cyc_q + 5'h01;
            end
            if (!en_next) begin
                first_q <= 1'b0;
            end else if (start_any) begin
                first_q <= 1'b0;
            end else if (enabling) begin
                first_q <= 1'b1;
            end
        end
    end

    // restarting the prescaler at each start gives every conversion whole converter cycles
    always_ff @(posedge ref_clk) begin
        if (srst || !en_q || start_any || tick) begin
            pre_q <= 7'h00;
        end else begin
            pre_q <= pre_q + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {ref_sel_q, left_align_q, chan_q} <= 7'h00;
        end else if (wr_mux) begin
            ref_sel_q <= wbyte[7:6];
            left_align_q <= wbyte[`ACR_MUX_LEFT_ALIGN];
            chan_q <= wbyte[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {en_q, ate_q, ie_q, div_q} <= 6'h00;
            trig_sel_q <= 3'h0;
        end else begin
            if (wr_csa) begin
                en_q <= wbyte[`ACR_CSA_ENABLE];
                ate_q <= wbyte[`ACR_CSA_AUTO_TRIG];
                ie_q <= wbyte[`ACR_CSA_IRQ_EN];
                div_q <= wbyte[2:0];
            end
            if (wr_trig) begin
                trig_sel_q <= wbyte[2:0];
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= conv_done | (flag_q & ~flag_clr);
        end
    end

    // a result finishing while frozen is lost, as the flag still reports it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            res_q <= `ACR_RESET_RESULT;
            lock_q <= 1'b0;
        end else begin
            if (take_result) begin
                res_q <= analog_result;
            end
            if (rd_high_done) begin
                lock_q <= 1'b0;
            end else if (rd_low_done) begin
                lock_q <= 1'b1;
            end
        end
    end

    // routing follows the registers only between conversions
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            path_q <= '0;
        end else if (!busy_q || conv_done) begin
            path_q.reference_select <= acr_ref_t'(ref_sel_q);
            path_q.input_channel_select <= chan_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rsp_q <= '0;
            irq_q <= 1'b0;
        end else begin
            rsp_q.pready <= acc_phase & ~rsp_q.pready;
            rsp_q.pslverr <= acc_phase & ~rsp_q.pready & ~sel_any;
            rsp_q.prdata <= {24'h000000, view_any};
            irq_q <= ie_q & global_irq_enable & flag_q;
        end
    end

    assign apb_rsp = rsp_q;
    assign irq_req = irq_q;
    assign path_out = path_q;
    assign converter_on = en_q;
    assign conv_busy = busy_q;
    assign conv_long = long_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking acr_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic [4:0] chk_ticks_q;
    always_ff @(posedge ref_clk) begin
        if (srst || start_any) begin
            chk_ticks_q <= 5'h00;
        end else if (busy_q && tick) begin
            chk_ticks_q <= chk_ticks_q + 5'h01;
        end
    end

    sequence s_start_write;
        start_wr && !busy_q;
    endsequence
    sequence s_finish;
        conv_done;
    endsequence
    // the bench waits up to 20 cycles for pready, so pin exactly one wait state here
    sequence s_bus_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    a_start_sets_busy: assert property (s_start_write |=> busy_q && conv_busy)
        else $error("start write did not begin a conversion");
    a_conv_length: assert property (s_finish |->
        chk_ticks_q == (long_q ? 5'd24 : 5'd12))
        else $error("conversion length in converter cycles is wrong");
    a_disable_abort: assert property ($fell(en_q) |-> !busy_q)
        else $error("disable did not abort conversion");
    a_finish_flag: assert property (s_finish ##1 !busy_q[*1] |-> flag_q || $past(flag_clr))
        else $error("flag not set at completion");
    a_ack_clears: assert property (irq_vector_ack && !conv_done |=> !flag_q)
        else $error("vector entry did not clear flag");
    a_irq_gate: assert property (irq_req |-> $past(flag_q && ie_q && global_irq_enable))
        else $error("interrupt requested without all enables");
    a_result_frozen: assert property (lock_q && !rd_high_done |=> $stable(res_q))
        else $error("result changed while frozen");
    a_path_deferred: assert property (busy_q && !conv_done |=> $stable(path_out))
        else $error("routing changed during conversion");
    a_mux_bit4_zero: assert property (acc_phase && !rsp_q.pready && sel_mux |=>
        apb_rsp.prdata[4] == 1'b0)
        else $error("reserved input select bit read nonzero");
    a_free_run_go: assert property ((s_finish and (free_run && en_q && !wr_csa)) |=> busy_q)
        else $error("free running did not restart");
    a_bus_one_wait: assert property (s_bus_setup ##1 acc_phase |=> apb_rsp.pready)
        else $error("bus answer not after one wait state");
    a_done_sets_flag: assert property (conv_done |=> flag_q)
        else $error("completion did not set flag");
    a_zero_start_idle: assert property (wr_csa && !wbyte[`ACR_CSA_START] && !busy_q &&
        !start_trig |=> !busy_q)
        else $error("zero start write began a conversion");
    a_off_not_busy: assert property (!converter_on |-> !conv_busy)
        else $error("busy while converter off");
    a_trig_starts: assert property (start_trig && !busy_q && !wr_csa |=> conv_busy)
        else $error("trigger edge did not start a conversion");
    a_left_high_view: assert property (left_align_q && sel_high && acc_phase &&
        !rsp_q.pready |=> apb_rsp.prdata[7:0] == $past(res_q[9:2]))
        else $error("left aligned high byte view is wrong");

endmodule : acr_ctrl

/* File: tb/tb_adc_control_registers.sv */
// Purpose: self-checking bench for the converter control block over APB
// Assumes: pready within 20 cycles of the access phase; result view reshaped by the left-align bit
// Notes: conversion lengths are counted as cycles with conv_busy high
`timescale 1ns/1ps
`include "acr_params.svh"

module tb_adc_control_registers;
    import acr_pkg::*;

    localparam logic [11:0] AD_LO = {2'b00, `ACR_IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] AD_HI = {2'b00, `ACR_IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] AD_CSA = {2'b00, `ACR_IDX_CTRL_STATUS_A, 2'b00};
    localparam logic [11:0] AD_TRG = {2'b00, `ACR_IDX_TRIG_SELECT, 2'b00};
    localparam logic [11:0] AD_MUX = {2'b00, `ACR_IDX_INPUT_SELECT, 2'b00};

    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    acr_apb_req_t req = '0;
    acr_apb_rsp_t rsp;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic irq;
    logic [7:0] trg = 8'h00;
    logic [9:0] ares = 10'h000;
    acr_path_t path;
    logic on;
    logic busy;
    logic lng;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] r;
    logic e;

    always #2 ref_clk = ~ref_clk;

    acr_ctrl uut (
        .ref_clk(ref_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .global_irq_enable(gie), .irq_vector_ack(ack), .irq_req(irq),
        .trigger_flags(trg), .analog_result(ares), .path_out(path),
        .converter_on(on), .conv_busy(busy), .conv_long(lng)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (rsp.pready === 1'b1) break;
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (i == 20) begin
            fails++;
            $display("Error at %0t: bus answer missing", $time);
            wrap_up();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rchk

    // counts busy cycles; a negative figure skips the comparison
    task automatic measure(input int exp);
        int n;
        n = 0;
        #1;
        while (busy === 1'b1 && n < 3000) begin
            n++;
            @(posedge ref_clk);
            #1;
        end
        if (n == 3000) begin
            fails++;
            $display("Error at %0t: conversion never ended", $time);
            wrap_up();
        end
        if (exp >= 0) chk(n, exp);
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] chans [4];
        chans = '{4'h0, 4'h7, 4'h8, 4'hE};
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        rchk(AD_LO, 32'h0);
        rchk(AD_HI, 32'h0);
        rchk(AD_CSA, 32'h0);
        rchk(AD_MUX, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(AD_MUX, 32'hFF);
        rchk(AD_MUX, 32'hEF);
        for (int k = 0; k < 4; k++) begin
            wr(AD_MUX, {24'h0, k[1:0], 2'b00, chans[k]});
            @(posedge ref_clk);
            #1;
            chk({26'h0, path}, {26'h0, k[1:0], chans[k]});
        end
        // first conversion after enabling, divide by 2
        @(posedge ref_clk);
        ares <= 10'h2A5;
        gie <= 1'b1;
        wr(AD_CSA, 32'hC8);
        #1;
        chk({31'h0, lng}, 32'h1);
        measure(50);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        @(posedge ref_clk);
        gie <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        rchk(AD_CSA, 32'h98);
        rchk(AD_LO, 32'hA5);
        rchk(AD_HI, 32'h02);
        wr(AD_CSA, 32'h9B);
        rchk(AD_CSA, 32'h8B);
        // later conversion, divide by 8
        ares <= 10'h1C3;
        wr(AD_CSA, 32'hCB);
        #1;
        chk({31'h0, lng}, 32'h0);
        measure(104);
        // mid-conversion: deferred path, immediate alignment, zero start write
        @(posedge ref_clk);
        ares <= 10'h3FF;
        wr(AD_CSA, 32'hCB);
        wr(AD_CSA, 32'h8B);
        rchk(AD_CSA, 32'hDB);
        wr(AD_MUX, 32'h65);
        #1;
        chk({26'h0, path}, {26'h0, 2'b11, 4'hE});
        rchk(AD_LO, 32'hC0);
        rchk(AD_HI, 32'h70);
        measure(-1);
        @(posedge ref_clk);
        #1;
        chk({26'h0, path}, {26'h0, 2'b01, 4'h5});
        // low read freezes the high byte across a later conversion
        rchk(AD_LO, 32'hC0);
        ares <= 10'h000;
        wr(AD_CSA, 32'hCB);
        measure(-1);
        rchk(AD_HI, 32'hFF);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        rchk(AD_CSA, 32'h8B);
        // auto trigger on source 2, then switch to free run with flag set
        wr(AD_TRG, 32'h2);
        wr(AD_CSA, 32'hA0);
        trg <= 8'h04;
        @(posedge ref_clk);
        #1;
        chk({31'h0, busy}, 32'h1);
        measure(26);
        // source 0 must ignore flag bit 0 even when it is high
        @(posedge ref_clk);
        trg <= 8'h01;
        wr(AD_TRG, 32'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({31'h0, busy}, 32'h0);
        // free running: old flag cleared, one start, restarts by itself
        wr(AD_CSA, 32'hF0);
        repeat (40) @(posedge ref_clk);
        #1;
        chk({31'h0, busy}, 32'h1);
        rchk(AD_CSA, 32'hF0);
        wr(AD_CSA, 32'h00);
        @(posedge ref_clk);
        #1;
        chk({30'h0, busy, on}, 32'h0);
        wrap_up();
    end

    initial begin
        #300000;
        fails++;
        $display("Error at %0t: run too long", $time);
        wrap_up();
    end
endmodule : tb_adc_control_registers
